// [pkg/fault_status_pkg.sv]
// Constants for the fault event and live attach status register pair.
// Assumes one system clock; every status input is asynchronous to it.
// Notes on behaviour
// R1: Fault flag reaches interrupt only when masked in
// R2: Pre-bias flag: Type-C on, no sink, output high
// R3: Heat warning flag sets at warning threshold
// R4: Heat warning with foldback lowers advertised current, limit
// R5: Read clears flag only when cause gone
// R6: Bit 2 flags supply input overvoltage
// R7: Bit 1 flags data line overvoltage
// R8: Status register is live, read has no effect
// R9: Status bit 4 shows Type-C sink attached
// R10: Status bit 3 shows charger detect attach state
// R11: Status bit 2 high while output below safe level
// R12: Status bit 0 high while output power applied
// R13: Reserved bits read zero, writes do nothing
package fault_status_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [7:0] FAULT_EVENT_FLAGS_B_OFS = 8'h0c;
  localparam logic [7:0] LIVE_ATTACH_STATUS_OFS  = 8'h0d;

  // Fault register field positions
  localparam int unsigned OUTPUT_PREBIAS_BIT      = 5;
  localparam int unsigned DIE_HEAT_WARNING_BIT    = 3;
  localparam int unsigned SUPPLY_INPUT_OVERVOLT_BIT = 2;
  localparam int unsigned DATA_LINE_OVERVOLT_BIT  = 1;

  // Status register field positions
  localparam int unsigned TYPEC_SINK_PRESENT_BIT      = 4;
  localparam int unsigned CHARGER_DETECT_PRESENT_BIT  = 3;
  localparam int unsigned OUTPUT_BELOW_SAFE_LEVEL_BIT = 2;
  localparam int unsigned OUTPUT_POWER_APPLIED_BIT    = 0;

  // Implemented bits of each register; all others read zero
  localparam logic [7:0] FAULT_USED_MASK  = 8'h2e;
  localparam logic [7:0] STATUS_USED_MASK = 8'h1d;

  // Values after reset
  localparam logic [7:0] FAULT_RESET_VALUE = 8'h00;
  localparam logic [7:0] RDATA_RESET_VALUE = 8'h00;

  // Synchroniser inputs, in this order on the sync vector
  localparam int unsigned SYNC_W          = 9;
  localparam int unsigned S_TYPEC_EN      = 0;
  localparam int unsigned S_SINK          = 1;
  localparam int unsigned S_CHARGER       = 2;
  localparam int unsigned S_ABOVE_SAFE    = 3;
  localparam int unsigned S_HEAT          = 4;
  localparam int unsigned S_SUPPLY_INPUT_OVERVOLT_FLAG         = 5;
  localparam int unsigned S_DATA_LINE_OVERVOLT_FLAG       = 6;
  localparam int unsigned S_POWER_APPLIED = 7;
  localparam int unsigned S_FOLDBACK_EN   = 8;
  localparam logic [SYNC_W-1:0] SYNC_RESET_VALUE = 9'h000;

endpackage

// [sim/fault_and_attach_status_regs_tb.sv]
// Bench for the fault flag and live status registers.
// Assumes the status_host model as the reading party.
`timescale 1ns/10ps
module fault_and_attach_status_regs_tb;
  import fault_status_pkg::*;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, done, rd, rvalid, irq, fold;
  logic [7:0] adr = 8'h00, mask = 8'h00, radr, rdat, rdata;
  logic [SYNC_W-1:0] pin = '0;
  int n_fail = 0, checks_done = 0;
  always #2 clk = ~clk;
  fault_and_attach_status_regs fault_and_attach_status_regs_i (.CLK(clk), .RESET(rst),
    .TYPEC_ENABLE(pin[S_TYPEC_EN]), .TYPEC_SINK_PRESENT(pin[S_SINK]),
    .CHARGER_DETECT_PRESENT(pin[S_CHARGER]), .OUTPUT_VOLTAGE_MONITOR_ABOVE_SAFE(pin[S_ABOVE_SAFE]),
    .DIE_HEAT_WARNING(pin[S_HEAT]), .SUPPLY_INPUT_OVERVOLT(pin[S_SUPPLY_INPUT_OVERVOLT_FLAG]),
    .DATA_LINE_OVERVOLT(pin[S_DATA_LINE_OVERVOLT_FLAG]), .OUTPUT_POWER_APPLIED(pin[S_POWER_APPLIED]),
    .THERMAL_FOLDBACK_ENABLE(pin[S_FOLDBACK_EN]), .IRQ_MASK(mask), .REG_RD(rd),
    .REG_ADDR(radr), .REG_RDATA(rdat), .REG_RVALID(rvalid), .IRQ_OUT(irq),
    .CURRENT_FOLDBACK(fold));
  status_host status_host_i (.CLK(clk), .go(go), .addr(adr), .REG_RD(rd), .REG_ADDR(radr),
    .REG_RVALID(rvalid), .REG_RDATA(rdat), .rdata(rdata), .done(done));
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    int k;
    go <= 1'b1;
    adr <= a;
    wt(1);
    go <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 8) begin
      wt(1);
      k++;
    end
    if (done !== 1'b1) begin
      n_fail++;
      $display("Error at %0t: no read answer", $time);
    end
    chk(rdata, e);
  endtask
  task automatic t_idle;
    chk({7'h0, irq}, 8'h00);
    rd_chk(FAULT_EVENT_FLAGS_B_OFS, 8'h00);
    rd_chk(LIVE_ATTACH_STATUS_OFS, 8'h04);
    rd_chk(8'h0e, 8'h00);
    $display("t_idle done");
  endtask
  task automatic t_fault;
    // Heat, input and data pins sit at index 7-b for flag bit b
    for (int b = 1; b <= 3; b++) begin
      pin[7-b] <= 1'b1;
      pin[S_FOLDBACK_EN] <= 1'b1;
      wt(6);
      chk({7'h0, irq}, 8'h00);
      mask <= 8'h01 << b;
      wt(2);
      chk({7'h0, irq}, 8'h01);
      chk({7'h0, fold}, {7'h0, b == 3});
      rd_chk(FAULT_EVENT_FLAGS_B_OFS, 8'h01 << b);
      rd_chk(FAULT_EVENT_FLAGS_B_OFS, 8'h01 << b);
      pin[7-b] <= 1'b0;
      wt(6);
      rd_chk(FAULT_EVENT_FLAGS_B_OFS, 8'h01 << b);
      rd_chk(FAULT_EVENT_FLAGS_B_OFS, 8'h00);
      wt(2);
      chk({6'h0, irq, fold}, 8'h00);
      mask <= 8'h00;
    end
    $display("t_fault done");
  endtask
  task automatic t_prebias;
    pin[S_TYPEC_EN] <= 1'b1;
    pin[S_ABOVE_SAFE] <= 1'b1;
    wt(6);
    rd_chk(FAULT_EVENT_FLAGS_B_OFS, 8'h20);
    pin[S_SINK] <= 1'b1;
    wt(6);
    rd_chk(FAULT_EVENT_FLAGS_B_OFS, 8'h20);
    rd_chk(FAULT_EVENT_FLAGS_B_OFS, 8'h00);
    $display("t_prebias done");
  endtask
  task automatic t_status;
    pin[S_CHARGER] <= 1'b1;
    pin[S_POWER_APPLIED] <= 1'b1;
    wt(6);
    rd_chk(LIVE_ATTACH_STATUS_OFS, 8'h19);
    rd_chk(LIVE_ATTACH_STATUS_OFS, 8'h19);
    pin <= '0;
    wt(6);
    rd_chk(LIVE_ATTACH_STATUS_OFS, 8'h04);
    $display("t_status done");
  endtask
  initial begin
    wt(16);
    rst <= 1'b0;
    wt(3);
    t_idle;
    t_fault;
    t_prebias;
    t_status;
    wrap_up;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    wrap_up;
  end
endmodule // fault_and_attach_status_regs_tb

// [sim/status_host.sv]
// Host model: one register read per go pulse, answer captured in rdata.
// Assumes the read port answers one cycle after the strobe is taken.
`timescale 1ns/10ps
module status_host (
  input  wire logic       CLK,
  input  wire logic       go,
  input  wire logic [7:0] addr,
  output logic            REG_RD,
  output logic      [7:0] REG_ADDR,
  input  wire logic       REG_RVALID,
  input  wire logic [7:0] REG_RDATA,
  output logic      [7:0] rdata,
  output logic            done
);
  initial begin
    REG_RD = 1'b0;
    REG_ADDR = 8'h00;
    rdata = 8'h00;
    done = 1'b0;
  end
  always @(posedge CLK) begin
    REG_RD <= go;
    // Address is not held once the strobe drops
    REG_ADDR <= go ? addr : ~REG_ADDR;
    done <= REG_RVALID;
    if (REG_RVALID) rdata <= REG_RDATA;
  end
endmodule // status_host

// [src/fault_and_attach_status_regs.sv]
// Fault event flag register and live attach status register with read port.
// Assumes status inputs come from analog comparators outside the clock domain
// and the interrupt mask arrives from register logic on the same clock.
`timescale 1ns/10ps

module fault_and_attach_status_regs
  import fault_status_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RESET,
  input  wire logic              TYPEC_ENABLE,
  input  wire logic              TYPEC_SINK_PRESENT,
  input  wire logic              CHARGER_DETECT_PRESENT,
  input  wire logic              OUTPUT_VOLTAGE_MONITOR_ABOVE_SAFE,
  input  wire logic              DIE_HEAT_WARNING,
  input  wire logic              SUPPLY_INPUT_OVERVOLT,
  input  wire logic              DATA_LINE_OVERVOLT,
  input  wire logic              OUTPUT_POWER_APPLIED,
  input  wire logic              THERMAL_FOLDBACK_ENABLE,
  input  wire logic [DATA_W-1:0] IRQ_MASK,
  input  wire logic              REG_RD,
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  output logic      [DATA_W-1:0] REG_RDATA,
  output logic                   REG_RVALID,
  output logic                   IRQ_OUT,
  output logic                   CURRENT_FOLDBACK
);

  logic [SYNC_W-1:0] async_in;
  logic [SYNC_W-1:0] sync_stage1_reg;
  logic [SYNC_W-1:0] sync_reg;

  assign async_in = {THERMAL_FOLDBACK_ENABLE, OUTPUT_POWER_APPLIED, DATA_LINE_OVERVOLT,
                     SUPPLY_INPUT_OVERVOLT, DIE_HEAT_WARNING,
                     OUTPUT_VOLTAGE_MONITOR_ABOVE_SAFE, CHARGER_DETECT_PRESENT,
                     TYPEC_SINK_PRESENT, TYPEC_ENABLE};

  // Two-flop synchroniser per input; first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge CLK) begin
        if (RESET) begin
          sync_stage1_reg[gi] <= SYNC_RESET_VALUE[gi];
          sync_reg[gi]        <= SYNC_RESET_VALUE[gi];
        end else begin
          sync_stage1_reg[gi] <= async_in[gi];
          sync_reg[gi]        <= sync_stage1_reg[gi];
        end
      end
    end
  endgenerate

  // Current causes of each fault flag
  logic [DATA_W-1:0] fault_cause;
  logic [DATA_W-1:0] status_live;
  logic              fault_read;
  logic              status_read;

  always_comb begin
    fault_cause = '0;
    fault_cause[OUTPUT_PREBIAS_BIT] = sync_reg[S_TYPEC_EN] & ~sync_reg[S_SINK]
                                      & sync_reg[S_ABOVE_SAFE]; // see R2
    fault_cause[DIE_HEAT_WARNING_BIT]      = sync_reg[S_HEAT];    // see R3
    fault_cause[SUPPLY_INPUT_OVERVOLT_BIT] = sync_reg[S_SUPPLY_INPUT_OVERVOLT_FLAG];   // see R6
    fault_cause[DATA_LINE_OVERVOLT_BIT]    = sync_reg[S_DATA_LINE_OVERVOLT_FLAG]; // see R7
  end

  // Live status, sampled straight from the synchronised inputs
  always_comb begin
    status_live = '0;
    status_live[TYPEC_SINK_PRESENT_BIT]      = sync_reg[S_SINK];          // see R9
    status_live[CHARGER_DETECT_PRESENT_BIT]  = sync_reg[S_CHARGER];       // see R10
    status_live[OUTPUT_BELOW_SAFE_LEVEL_BIT] = ~sync_reg[S_ABOVE_SAFE];   // see R11
    status_live[OUTPUT_POWER_APPLIED_BIT]    = sync_reg[S_POWER_APPLIED]; // see R12
  end

  assign fault_read  = REG_RD && (REG_ADDR == FAULT_EVENT_FLAGS_B_OFS);
  assign status_read = REG_RD && (REG_ADDR == LIVE_ATTACH_STATUS_OFS);

  // Fault flag state
  logic [DATA_W-1:0] fault_reg;
  logic [DATA_W-1:0] fault_next;

  // Set wins: an event that lands in the read cycle is never lost
  always_comb begin
    fault_next = fault_reg;
    if (fault_read) begin
      fault_next = fault_reg & fault_cause; // see R5
    end
    fault_next = (fault_next | fault_cause) & FAULT_USED_MASK; // Set wins over clear
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      fault_reg <= FAULT_RESET_VALUE;
    end else begin
      fault_reg <= fault_next;
    end
  end

  // Read port; there is no write path, so writes cannot change either register
  logic [DATA_W-1:0] rdata_next;
  logic              rvalid_next;

  always_comb begin
    rvalid_next = REG_RD;
    rdata_next  = RDATA_RESET_VALUE;
    if (fault_read) begin
      rdata_next = fault_reg & FAULT_USED_MASK; // see R13
    end else if (status_read) begin
      rdata_next = status_live & STATUS_USED_MASK; // see R8
    end
  end

  // Interrupt and foldback outputs
  logic irq_next;
  logic foldback_next;

  always_comb begin
    irq_next      = |(fault_reg & IRQ_MASK); // see R1
    foldback_next = fault_reg[DIE_HEAT_WARNING_BIT] & sync_reg[S_FOLDBACK_EN]; // see R4
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      REG_RDATA        <= RDATA_RESET_VALUE;
      REG_RVALID       <= 1'b0;
      IRQ_OUT          <= 1'b0;
      CURRENT_FOLDBACK <= 1'b0;
    end else begin
      REG_RDATA        <= rdata_next;
      REG_RVALID       <= rvalid_next;
      IRQ_OUT          <= irq_next;
      CURRENT_FOLDBACK <= foldback_next;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence seq_fault_read;
    REG_RD && (REG_ADDR == FAULT_EVENT_FLAGS_B_OFS);
  endsequence

  sequence seq_status_read;
    REG_RD && (REG_ADDR == LIVE_ATTACH_STATUS_OFS);
  endsequence

  sequence seq_unmapped_read;
    REG_RD && (REG_ADDR != FAULT_EVENT_FLAGS_B_OFS) && (REG_ADDR != LIVE_ATTACH_STATUS_OFS);
  endsequence

  // Checks on flag setting, clearing, live status and the read port

  chk_irq_mask_gate: assert property ( // see R1
    IRQ_OUT == $past(|(fault_reg & IRQ_MASK)))
    else $error("interrupt output does not follow masked flags");

  chk_prebias_set: assert property ( // see R2
    (sync_reg[S_TYPEC_EN] && !sync_reg[S_SINK] && sync_reg[S_ABOVE_SAFE])
    |=> fault_reg[OUTPUT_PREBIAS_BIT])
    else $error("pre-bias flag not set");

  chk_heat_set: assert property ( // see R3
    sync_reg[S_HEAT] |=> fault_reg[DIE_HEAT_WARNING_BIT])
    else $error("heat warning flag not set");

  chk_foldback_out: assert property ( // see R4
    (fault_reg[DIE_HEAT_WARNING_BIT] && sync_reg[S_FOLDBACK_EN]) |=> CURRENT_FOLDBACK)
    else $error("foldback not applied during heat warning");

  chk_foldback_off: assert property ( // see R4
    !(fault_reg[DIE_HEAT_WARNING_BIT] && sync_reg[S_FOLDBACK_EN]) |=> !CURRENT_FOLDBACK)
    else $error("foldback applied without heat warning");

  chk_read_keeps_cause: assert property ( // see R5
    seq_fault_read |=> (fault_reg & $past(fault_cause)) == $past(fault_cause))
    else $error("persisting flag cleared by read");

  chk_read_clears_gone: assert property ( // see R5
    seq_fault_read ##0 (fault_cause == '0) |=> fault_reg == '0)
    else $error("flag survived read after cause gone");

  chk_supply_input_overvolt_flag_set: assert property ( // see R6
    sync_reg[S_SUPPLY_INPUT_OVERVOLT_FLAG] |=> fault_reg[SUPPLY_INPUT_OVERVOLT_BIT])
    else $error("input overvoltage flag not set");

  chk_data_line_overvolt_flag_set: assert property ( // see R7
    sync_reg[S_DATA_LINE_OVERVOLT_FLAG] |=> fault_reg[DATA_LINE_OVERVOLT_BIT])
    else $error("data line overvoltage flag not set");

  chk_status_live: assert property ( // see R8
    seq_status_read |=> REG_RVALID && (REG_RDATA == $past(status_live)))
    else $error("status read does not show live state");

  chk_status_no_clear: assert property ( // see R8
    seq_status_read |=> fault_reg == (($past(fault_reg) | $past(fault_cause)) & FAULT_USED_MASK))
    else $error("status read disturbed fault flags");

  chk_status_sink: assert property ( // see R9
    seq_status_read |=> REG_RDATA[TYPEC_SINK_PRESENT_BIT] == $past(sync_reg[S_SINK]))
    else $error("status sink bit wrong");

  chk_status_charger: assert property ( // see R10
    seq_status_read |=> REG_RDATA[CHARGER_DETECT_PRESENT_BIT] == $past(sync_reg[S_CHARGER]))
    else $error("status charger detect bit wrong");

  chk_status_safe: assert property ( // see R11
    seq_status_read |=> REG_RDATA[OUTPUT_BELOW_SAFE_LEVEL_BIT] == !$past(sync_reg[S_ABOVE_SAFE]))
    else $error("status safe level bit wrong");

  chk_status_power: assert property ( // see R12
    seq_status_read |=> REG_RDATA[OUTPUT_POWER_APPLIED_BIT] == $past(sync_reg[S_POWER_APPLIED]))
    else $error("status power applied bit wrong");

  chk_status_reserved: assert property ( // see R13
    seq_status_read |=> (REG_RDATA & ~STATUS_USED_MASK) == '0)
    else $error("reserved status bits not zero");

  chk_unmapped_zero: assert property ( // see R13
    seq_unmapped_read |=> REG_RVALID && (REG_RDATA == '0))
    else $error("unmapped read returned data");

  chk_reserved_zero: assert property ( // see R13
    seq_fault_read |=> (REG_RDATA & ~FAULT_USED_MASK) == '0)
    else $error("reserved fault bits not zero");

endmodule // fault_and_attach_status_regs
